/* File: hdlcdc_pkg.sv */
// Purpose: Constants, register map and types of the HDLC data-link controller
// Assumes: One 25 MHz clock; link bits qualified by per-bit enables
// Notes:   Offsets are byte addresses on an AHB-Lite bus with 32-bit data
//
// Contract
// - With auto-abort enabled, an abrupt switch from a message frame to bit-oriented mode sends a zero and seven ones.
// - With receive checking enabled, every received message frame has its check sequence verified.
// - With duplicate discard on, a received frame identical to the stored one is dropped.
// - While forced abort is set, the transmitter sends a run of seven or more ones.
// - While forced idle is set and forced abort is clear, the transmitter sends only flag octets, overriding pending frames.
// - In normal operation the transmitter fills the channel with flags when no message frame waits.
// - Forced idle is ignored in bit-oriented mode.
// - With transmit check enabled, check octets are appended to each outbound message frame.
// - The transmit check enable is ignored in bit-oriented mode.
// - The signaling select bit puts both directions in bit-oriented mode at 0 and message mode at 1.

package hdlcdc_pkg;

  // Register byte offsets
  localparam logic [7:0]  CTRL_OFS     = 8'h00;
  localparam logic [7:0]  TXD_OFS      = 8'h04;
  localparam logic [7:0]  STAT_OFS     = 8'h08;
  localparam logic [7:0]  BOS_OFS      = 8'h0C;
  localparam int          RXB_WIN_BIT  = 7;      // Offsets 0x80..0xFC read the stored frame

  // Control register fields (datalink_control)
  localparam int          CTL_SIG      = 0;      // signaling_select
  localparam int          CTL_TXFCS    = 1;      // tx_check_enable
  localparam int          CTL_IDLE     = 2;      // forced idle
  localparam int          CTL_ABORT    = 3;      // forced abort
  localparam int          CTL_DUP      = 4;      // rx_duplicate_discard
  localparam int          CTL_RXDIS    = 5;      // rx_check_disable
  localparam int          CTL_AADIS    = 6;      // auto_abort_disable
  localparam int          CTL_W        = 7;
  localparam logic [6:0]  CTL_RST      = 7'h00;

  // Transmit data register and status fields
  localparam int          TXD_EOF_BIT  = 8;
  localparam int          STAT_ERR_BIT = 24;

  // Line octets and check sequence
  localparam logic [7:0]  FLAG_OCT     = 8'h7E;
  localparam logic [7:0]  ABORT_OCT    = 8'hFE;  // Zero first, then seven ones
  localparam logic [7:0]  ONES_OCT     = 8'hFF;
  localparam logic [15:0] CRC_INIT     = 16'hFFFF;
  localparam logic [15:0] CRC_POLY     = 16'h8408;
  localparam logic [15:0] CRC_GOOD     = 16'hF0B8;
  localparam logic [2:0]  STUFF_RUN    = 3'h5;

  // Buffer sizes
  localparam int          FIFO_W       = 9;
  localparam int          FIFO_D       = 32;
  localparam logic [5:0]  RX_BUF_D     = 6'h20;
  localparam logic [5:0]  RX_MIN_LEN   = 6'h02;

  // Transmit octet source
  typedef enum logic [2:0] {
    TX_FLAG  = 3'b000,
    TX_DATA  = 3'b001,
    TX_FCS   = 3'b010,
    TX_ABRT  = 3'b011,
    TX_BOS   = 3'b100
  } hdlcdc_tx_st_t;

endpackage

/* File: hdlcdc_crc.sv */
// Purpose: Advance the 16-bit frame check sequence by one octet
// Assumes: Octets enter least significant bit first
// Notes:   Purely combinational
`timescale 1ns/1ps
`default_nettype none

module hdlcdc_crc (
  // Running value and octet
  input  wire logic [15:0] crc_i,
  input  wire logic [7:0]  data_i,
  // Updated value
  output logic      [15:0] crc_o
);

  // Reflected shift, one step per bit
  always_comb begin
    crc_o = crc_i;
    for (int i = 0; i < 8; i++) begin
      if (crc_o[0] ^ data_i[i]) begin
        crc_o = (crc_o >> 1) ^ hdlcdc_pkg::CRC_POLY;
      end else begin
        crc_o = crc_o >> 1;
      end
    end
  end

endmodule

`default_nettype wire

/* File: hdlcdc_fifo.sv */
// Purpose: Synchronous FIFO between register bus and transmitter
// Assumes: One clock, valid/ready on both sides
// Notes:   DEPTH must be a power of two
`timescale 1ns/1ps
`default_nettype none

module hdlcdc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  // Honest flags from the occupancy count
  assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem[rp_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Pointer and count update
  always_comb begin
    wp_nxt  = push ? AW'(wp_r + 1'b1) : wp_r;
    rp_nxt  = pop ? AW'(rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = (AW+1)'(cnt_r + 1'b1);
    end else if (pop && !push) begin
      cnt_nxt = (AW+1)'(cnt_r - 1'b1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage needs no reset; only written entries are ever read
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp_r] <= in_data_i;
    end
  end

endmodule

`default_nettype wire

/* File: hdlcdc_top.sv */
// Purpose: HDLC data-link controller with AHB-Lite registers, serial tx and rx
// Assumes: Link bits move one per cycle on which the matching bit enable is high
// Notes:   Bit-oriented transmit sends FIFO octets raw, without stuffing or check
//
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module hdlcdc_top (
  // Clock and reset
  input  wire logic        CLOCK_I,
  input  wire logic        RST_N_I,
  // AHB-Lite slave
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  // Data-link channel
  input  wire logic        TX_BIT_EN_I,
  output logic             TX_BIT_O,
  input  wire logic        RX_BIT_EN_I,
  input  wire logic        RX_BIT_I
);

  // Bus data phase state
  logic        dp_vld_r, dp_vld_nxt, dp_wr_r, dp_wr_nxt;
  logic [7:0]  dp_adr_r, dp_adr_nxt;
  logic [31:0] rdata_r, rdata_nxt, rd_mux;
  logic        take, stall, wdone;
  // Registers
  logic [6:0]  ctrl_r, ctrl_nxt;
  logic        err_r, err_nxt;
  // FIFO link
  logic        fifo_in_vld, fifo_in_rdy, fifo_out_vld, tx_pop;
  logic [8:0]  fifo_out_dat;
  // Transmitter
  hdlcdc_pkg::hdlcdc_tx_st_t tx_st_r, tx_st_nxt;
  logic [7:0]  tx_sh_r, tx_sh_nxt;
  logic [2:0]  tx_cnt_r, tx_cnt_nxt, tx_ones_r, tx_ones_nxt;
  logic        tx_bit_r, tx_bit_nxt, tx_last_r, tx_last_nxt;
  logic        tx_fcs2_r, tx_fcs2_nxt, tx_infr_r, tx_infr_nxt, tx_stuffed;
  logic [15:0] tx_crc_r, tx_crc_nxt, tx_crc_base, tx_crc_upd;
  // Receiver
  logic [15:0] rx_hist_r, rx_hist_nxt, rx_crc_r, rx_crc_nxt, rx_crc_upd;
  logic [7:0]  rx_byte_r, rx_byte_nxt, rx_byte_new, rx_nfrm_r, rx_nfrm_nxt;
  logic [7:0]  rx_ndup_r, rx_ndup_nxt, rx_cmp;
  logic [2:0]  rx_ones_r, rx_ones_nxt, rx_bcnt_r, rx_bcnt_nxt;
  logic [5:0]  rx_len_r, rx_len_nxt, rx_slen_r, rx_slen_nxt, rx_bos_r, rx_bos_nxt;
  logic        rx_act_r, rx_act_nxt, rx_same_r, rx_same_nxt;
  logic        rx_bank_r, rx_bank_nxt, rx_bad, rx_we, rx_good;
  logic [7:0]  rx_mem [0:63];

  // AHB-Lite decode; only writes to the transmit data port can stall
  assign take        = HSEL_I & HREADY_I & HTRANS_I[1];
  assign stall       = dp_vld_r & dp_wr_r & (dp_adr_r == hdlcdc_pkg::TXD_OFS) & ~fifo_in_rdy;
  assign wdone       = dp_vld_r & dp_wr_r & ~stall;
  assign HREADYOUT_O = ~stall;
  assign HRESP_O     = 1'b0;
  assign HRDATA_O    = rdata_r;
  assign fifo_in_vld = dp_vld_r & dp_wr_r & (dp_adr_r == hdlcdc_pkg::TXD_OFS);

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (HADDR_I[hdlcdc_pkg::RXB_WIN_BIT]) begin
      rd_mux = {24'h00_0000, rx_mem[{rx_bank_r, HADDR_I[6:2]}]};
    end else begin
      unique case (HADDR_I[7:0])
        hdlcdc_pkg::CTRL_OFS: rd_mux = {25'h000_0000, ctrl_r};   // Reserved top bit reads zero
        hdlcdc_pkg::STAT_OFS: rd_mux = {7'h00, err_r, 2'h0, rx_slen_r, rx_ndup_r, rx_nfrm_r};
        hdlcdc_pkg::BOS_OFS:  rd_mux = {26'h000_0000, rx_bos_r};
        default:              rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Address phase capture and read data, held while the slave stalls
  always_comb begin
    dp_vld_nxt = dp_vld_r;
    dp_wr_nxt  = dp_wr_r;
    dp_adr_nxt = dp_adr_r;
    rdata_nxt  = rdata_r;
    if (HREADY_I) begin
      dp_vld_nxt = take;
      dp_wr_nxt  = HWRITE_I;
      dp_adr_nxt = HADDR_I[7:0];
      if (take && !HWRITE_I) begin
        rdata_nxt = rd_mux;
      end
    end
  end

  // Control register and sticky check error; a new error beats the clear
  always_comb begin
    ctrl_nxt = ctrl_r;
    err_nxt  = err_r;
    if (wdone && dp_adr_r == hdlcdc_pkg::CTRL_OFS) begin
      ctrl_nxt = HWDATA_I[6:0];   // Bit 7 is not stored
    end
    if (wdone && dp_adr_r == hdlcdc_pkg::STAT_OFS && HWDATA_I[hdlcdc_pkg::STAT_ERR_BIT]) begin
      err_nxt = 1'b0;
    end
    if (rx_bad) begin
      err_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      dp_vld_r <= 1'b0;
      dp_wr_r  <= 1'b0;
      dp_adr_r <= 8'h00;
      rdata_r  <= 32'h0000_0000;
      ctrl_r   <= hdlcdc_pkg::CTL_RST;
      err_r    <= 1'b0;
    end else begin
      dp_vld_r <= dp_vld_nxt;
      dp_wr_r  <= dp_wr_nxt;
      dp_adr_r <= dp_adr_nxt;
      rdata_r  <= rdata_nxt;
      ctrl_r   <= ctrl_nxt;
      err_r    <= err_nxt;
    end
  end

  // Outbound octets; a full FIFO stalls the bus write
  hdlcdc_fifo #(
    .WIDTH (hdlcdc_pkg::FIFO_W),
    .DEPTH (hdlcdc_pkg::FIFO_D)
  ) u_fifo (
    .clk_i       (CLOCK_I),
    .rst_n_i     (RST_N_I),
    .in_valid_i  (fifo_in_vld),
    .in_ready_o  (fifo_in_rdy),
    .in_data_i   (HWDATA_I[8:0]),
    .out_valid_o (fifo_out_vld),
    .out_ready_i (tx_pop),
    .out_data_o  (fifo_out_dat)
  );

  // Check sequence restarts at the first octet of each frame
  assign tx_crc_base = tx_infr_r ? tx_crc_r : hdlcdc_pkg::CRC_INIT;
  // The run counts only data and check bits, so a frame ending in five ones gets its zero before the flag
  assign tx_stuffed  = (tx_ones_r == hdlcdc_pkg::STUFF_RUN);

  hdlcdc_crc u_tx_crc (
    .crc_i  (tx_crc_base),
    .data_i (fifo_out_dat[7:0]),
    .crc_o  (tx_crc_upd)
  );

  // Transmit serialiser; the next octet is chosen as the last bit leaves
  always_comb begin
    tx_st_nxt   = tx_st_r;
    tx_sh_nxt   = tx_sh_r;
    tx_cnt_nxt  = tx_cnt_r;
    tx_ones_nxt = tx_ones_r;
    tx_bit_nxt  = tx_bit_r;
    tx_last_nxt = tx_last_r;
    tx_fcs2_nxt = tx_fcs2_r;
    tx_infr_nxt = tx_infr_r;
    tx_crc_nxt  = tx_crc_r;
    tx_pop      = 1'b0;
    if (TX_BIT_EN_I) begin
      if (tx_stuffed) begin
        tx_bit_nxt  = 1'b0;
        tx_ones_nxt = 3'h0;
      end else begin
        tx_bit_nxt  = tx_sh_r[0];
        tx_sh_nxt   = {1'b0, tx_sh_r[7:1]};
        tx_cnt_nxt  = tx_cnt_r + 3'h1;
        tx_ones_nxt = (tx_st_r == hdlcdc_pkg::TX_DATA || tx_st_r == hdlcdc_pkg::TX_FCS) && tx_sh_r[0] ?
                      tx_ones_r + 3'h1 : 3'h0;
        if (tx_cnt_r == 3'h7) begin
          if (ctrl_r[hdlcdc_pkg::CTL_ABORT]) begin
            tx_st_nxt   = hdlcdc_pkg::TX_ABRT;
            tx_sh_nxt   = hdlcdc_pkg::ONES_OCT;
            tx_infr_nxt = 1'b0;
          end else if (!ctrl_r[hdlcdc_pkg::CTL_SIG]) begin
            tx_infr_nxt = 1'b0;
            if (tx_infr_r && !ctrl_r[hdlcdc_pkg::CTL_AADIS]) begin
              tx_st_nxt = hdlcdc_pkg::TX_ABRT;
              tx_sh_nxt = hdlcdc_pkg::ABORT_OCT;
            end else begin
              // Raw octets, no check sequence in this mode
              tx_st_nxt = hdlcdc_pkg::TX_BOS;
              tx_sh_nxt = fifo_out_vld ? fifo_out_dat[7:0] : hdlcdc_pkg::ONES_OCT;
              tx_pop    = fifo_out_vld;
            end
          end else if (ctrl_r[hdlcdc_pkg::CTL_IDLE]) begin
            tx_st_nxt   = hdlcdc_pkg::TX_FLAG;
            tx_sh_nxt   = hdlcdc_pkg::FLAG_OCT;
            tx_infr_nxt = 1'b0;
          end else if (tx_st_r == hdlcdc_pkg::TX_DATA && tx_last_r) begin
            if (ctrl_r[hdlcdc_pkg::CTL_TXFCS]) begin
              tx_st_nxt   = hdlcdc_pkg::TX_FCS;
              tx_sh_nxt   = ~tx_crc_r[7:0];
              tx_fcs2_nxt = 1'b1;
            end else begin
              tx_st_nxt   = hdlcdc_pkg::TX_FLAG;
              tx_sh_nxt   = hdlcdc_pkg::FLAG_OCT;
              tx_infr_nxt = 1'b0;
            end
          end else if (tx_st_r == hdlcdc_pkg::TX_FCS && tx_fcs2_r) begin
            tx_sh_nxt   = ~tx_crc_r[15:8];
            tx_fcs2_nxt = 1'b0;
          end else if (tx_st_r == hdlcdc_pkg::TX_FCS) begin
            tx_st_nxt   = hdlcdc_pkg::TX_FLAG;
            tx_sh_nxt   = hdlcdc_pkg::FLAG_OCT;
            tx_infr_nxt = 1'b0;
          end else if (fifo_out_vld) begin
            tx_st_nxt   = hdlcdc_pkg::TX_DATA;
            tx_sh_nxt   = fifo_out_dat[7:0];
            tx_last_nxt = fifo_out_dat[hdlcdc_pkg::TXD_EOF_BIT];
            tx_crc_nxt  = tx_crc_upd;
            tx_infr_nxt = 1'b1;
            tx_pop      = 1'b1;
          end else if (tx_infr_r) begin
            // Underrun inside a frame; kill it rather than send garbage
            tx_st_nxt   = hdlcdc_pkg::TX_ABRT;
            tx_sh_nxt   = hdlcdc_pkg::ABORT_OCT;
            tx_infr_nxt = 1'b0;
          end else begin
            tx_st_nxt = hdlcdc_pkg::TX_FLAG;
            tx_sh_nxt = hdlcdc_pkg::FLAG_OCT;
          end
        end
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tx_st_r   <= hdlcdc_pkg::TX_FLAG;
      tx_sh_r   <= hdlcdc_pkg::FLAG_OCT;
      tx_cnt_r  <= 3'h0;
      tx_ones_r <= 3'h0;
      tx_bit_r  <= 1'b1;
      tx_last_r <= 1'b0;
      tx_fcs2_r <= 1'b0;
      tx_infr_r <= 1'b0;
      tx_crc_r  <= hdlcdc_pkg::CRC_INIT;
    end else begin
      tx_st_r   <= tx_st_nxt;
      tx_sh_r   <= tx_sh_nxt;
      tx_cnt_r  <= tx_cnt_nxt;
      tx_ones_r <= tx_ones_nxt;
      tx_bit_r  <= tx_bit_nxt;
      tx_last_r <= tx_last_nxt;
      tx_fcs2_r <= tx_fcs2_nxt;
      tx_infr_r <= tx_infr_nxt;
      tx_crc_r  <= tx_crc_nxt;
    end
  end

  assign TX_BIT_O = tx_bit_r;

  // Receive octet assembly and comparison with the stored frame
  assign rx_byte_new = {RX_BIT_I, rx_byte_r[7:1]};
  assign rx_cmp      = rx_mem[{rx_bank_r, rx_len_r[4:0]}];
  assign rx_good     = ctrl_r[hdlcdc_pkg::CTL_RXDIS] || (rx_crc_r == hdlcdc_pkg::CRC_GOOD);

  hdlcdc_crc u_rx_crc (
    .crc_i  (rx_crc_r),
    .data_i (rx_byte_new),
    .crc_o  (rx_crc_upd)
  );

  // Receiver; frames fill the idle bank, which becomes visible on acceptance
  always_comb begin
    rx_hist_nxt = rx_hist_r;
    rx_ones_nxt = rx_ones_r;
    rx_byte_nxt = rx_byte_r;
    rx_bcnt_nxt = rx_bcnt_r;
    rx_len_nxt  = rx_len_r;
    rx_act_nxt  = rx_act_r;
    rx_crc_nxt  = rx_crc_r;
    rx_same_nxt = rx_same_r;
    rx_bank_nxt = rx_bank_r;
    rx_slen_nxt = rx_slen_r;
    rx_nfrm_nxt = rx_nfrm_r;
    rx_ndup_nxt = rx_ndup_r;
    rx_bos_nxt  = rx_bos_r;
    rx_bad      = 1'b0;
    rx_we       = 1'b0;
    if (RX_BIT_EN_I) begin
      rx_hist_nxt = {RX_BIT_I, rx_hist_r[15:1]};
      rx_ones_nxt = !RX_BIT_I ? 3'h0 : (rx_ones_r == 3'h7 ? 3'h7 : rx_ones_r + 3'h1);
      if (!ctrl_r[hdlcdc_pkg::CTL_SIG]) begin
        // Codeword: eight ones, a zero, six message bits, a zero
        rx_act_nxt = 1'b0;
        if (rx_hist_nxt[7:0] == hdlcdc_pkg::ONES_OCT && !rx_hist_nxt[8] && !rx_hist_nxt[15]) begin
          if (ctrl_r[hdlcdc_pkg::CTL_DUP] && rx_hist_nxt[14:9] == rx_bos_r) begin
            rx_ndup_nxt = rx_ndup_r + 8'h01;
          end else begin
            rx_bos_nxt  = rx_hist_nxt[14:9];
            rx_nfrm_nxt = rx_nfrm_r + 8'h01;
          end
        end
      end else if (rx_hist_nxt[15:8] == hdlcdc_pkg::FLAG_OCT) begin
        // Seven flag bits were shifted in, so an aligned frame shows a count of seven
        if (rx_act_r && rx_bcnt_r == 3'h7 && rx_len_r >= hdlcdc_pkg::RX_MIN_LEN &&
            rx_len_r <= hdlcdc_pkg::RX_BUF_D) begin
          if (!rx_good) begin
            rx_bad = 1'b1;
          end else if (ctrl_r[hdlcdc_pkg::CTL_DUP] && rx_same_r && rx_len_r == rx_slen_r) begin
            rx_ndup_nxt = rx_ndup_r + 8'h01;
          end else begin
            rx_bank_nxt = ~rx_bank_r;
            rx_slen_nxt = rx_len_r;
            rx_nfrm_nxt = rx_nfrm_r + 8'h01;
          end
        end
        rx_act_nxt  = 1'b1;
        rx_len_nxt  = 6'h00;
        rx_bcnt_nxt = 3'h0;
        rx_crc_nxt  = hdlcdc_pkg::CRC_INIT;
        rx_same_nxt = 1'b1;
      end else if (rx_hist_nxt[15:9] == 7'h7F) begin
        rx_act_nxt = 1'b0;   // Abort from the far end drops the frame
      end else if (rx_act_r && !(!RX_BIT_I && rx_ones_r == hdlcdc_pkg::STUFF_RUN)) begin
        rx_byte_nxt = rx_byte_new;
        rx_bcnt_nxt = rx_bcnt_r + 3'h1;
        if (rx_bcnt_r == 3'h7) begin
          rx_crc_nxt = rx_crc_upd;
          if (rx_len_r < hdlcdc_pkg::RX_BUF_D) begin
            rx_we       = 1'b1;
            rx_same_nxt = rx_same_r && (rx_cmp == rx_byte_new);
          end
          if (rx_len_r <= hdlcdc_pkg::RX_BUF_D) begin
            rx_len_nxt = rx_len_r + 6'h01;   // Stops one past the buffer: too long
          end
        end
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rx_hist_r <= 16'h0000;
      rx_ones_r <= 3'h0;
      rx_byte_r <= 8'h00;
      rx_bcnt_r <= 3'h0;
      rx_len_r  <= 6'h00;
      rx_act_r  <= 1'b0;
      rx_crc_r  <= hdlcdc_pkg::CRC_INIT;
      rx_same_r <= 1'b0;
      rx_bank_r <= 1'b0;
      rx_slen_r <= 6'h00;
      rx_nfrm_r <= 8'h00;
      rx_ndup_r <= 8'h00;
      rx_bos_r  <= 6'h00;
    end else begin
      rx_hist_r <= rx_hist_nxt;
      rx_ones_r <= rx_ones_nxt;
      rx_byte_r <= rx_byte_nxt;
      rx_bcnt_r <= rx_bcnt_nxt;
      rx_len_r  <= rx_len_nxt;
      rx_act_r  <= rx_act_nxt;
      rx_crc_r  <= rx_crc_nxt;
      rx_same_r <= rx_same_nxt;
      rx_bank_r <= rx_bank_nxt;
      rx_slen_r <= rx_slen_nxt;
      rx_nfrm_r <= rx_nfrm_nxt;
      rx_ndup_r <= rx_ndup_nxt;
      rx_bos_r  <= rx_bos_nxt;
    end
  end

  // Two banks of frame storage; no reset, reads beyond the stored length are stale
  always_ff @(posedge CLOCK_I) begin
    if (rx_we) begin
      rx_mem[{~rx_bank_r, rx_len_r[4:0]}] <= rx_byte_new;
    end
  end

endmodule

`default_nettype wire

/* File: hdlcdc_assertions.sv */
// Purpose: Port checks of the data-link controller
// Assumes: One slave, HREADY_I tied to HREADYOUT_O
// Notes:   Control value is mirrored from bus writes
`timescale 1ns/1ps
`default_nettype none
module hdlcdc_chk (
  // Clock, reset and bus
  input  wire logic        CLOCK_I,
  input  wire logic        RST_N_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  input  wire logic [31:0] HRDATA_O,
  input  wire logic        HREADYOUT_O,
  input  wire logic        HRESP_O,
  // Link
  input  wire logic        TX_BIT_EN_I,
  input  wire logic        TX_BIT_O
);
  logic       ph_r, wr_r, en_r;
  logic [7:0] ad_r, hist_r;
  logic [6:0] mir_r, exp_r;
  logic [4:0] set_r;
  wire        take = HSEL_I & HREADY_I & HTRANS_I[1];
  // Data phase, control mirror, line history; settle count covers one frame tail
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ph_r <= 1'b0;
      wr_r <= 1'b0;
      en_r <= 1'b0;
      ad_r <= 8'h00;
      hist_r <= 8'h00;
      exp_r <= 7'h00;
      mir_r <= 7'h00;
      set_r <= 5'h00;
    end else begin
      en_r <= TX_BIT_EN_I;
      if (en_r) hist_r <= {TX_BIT_O, hist_r[7:1]};
      if (HREADY_I) begin
        ph_r <= take;
        wr_r <= HWRITE_I;
        ad_r <= HADDR_I[7:0];
        exp_r <= mir_r;
      end
      if (ph_r && HREADY_I && wr_r && ad_r == hdlcdc_pkg::CTRL_OFS) begin
        mir_r <= HWDATA_I[6:0];
        set_r <= 5'h00;
      end else if (TX_BIT_EN_I && set_r != 5'h1F) set_r <= set_r + 5'h01;
    end
  end
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_ctrl_rd;
    ph_r && !wr_r && ad_r == hdlcdc_pkg::CTRL_OFS;
  endsequence
  AST_CTRL_READBACK: assert property (s_ctrl_rd |-> HRDATA_O == {25'h0, exp_r})
    else $error("Control read-back wrong");
  AST_RESERVED_ZERO: assert property (s_ctrl_rd |-> !HRDATA_O[7])
    else $error("Reserved control bit reads one");
  AST_UNMAPPED_ZERO: assert property (ph_r && !wr_r && ad_r inside {[8'h10:8'h7C]} |-> HRDATA_O == 32'h0)
    else $error("Unmapped read not zero");
  AST_NO_WAIT: assert property (ph_r && !(wr_r && ad_r == hdlcdc_pkg::TXD_OFS) |-> HREADYOUT_O)
    else $error("Wait state on plain access");
  AST_RESP_OKAY: assert property (take |=> !HRESP_O)
    else $error("Response not okay");
  AST_TX_HOLD: assert property (!TX_BIT_EN_I |=> $stable(TX_BIT_O))
    else $error("Line bit moved without enable");
  AST_ABORT_ONES: assert property (mir_r[3] && set_r == 5'h1F && en_r |-> TX_BIT_O)
    else $error("Zero sent during forced abort");
  AST_IDLE_FLAGS: assert property (mir_r[0] && mir_r[2] && !mir_r[3] && set_r == 5'h1F |-> $countones(hist_r) == 6)
    else $error("Idle line not flags");
endmodule
bind hdlcdc_top hdlcdc_chk i_chk (.*);
`default_nettype wire

/* File: hdlcdc_far.sv */
// Purpose: Remote end that clocks the line and echoes it back
// Assumes: One bit every four clocks
// Notes:   Counts flags and the current run of ones seen
`timescale 1ns/1ps
`default_nettype none
module hdlcdc_far (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Line
  input  wire logic       tx_bit_i,
  output logic            tx_bit_en_o,
  output logic            rx_bit_en_o,
  output logic            rx_bit_o,
  // Observations
  output logic [3:0]      run_o,
  output logic [7:0]      flags_o
);
  logic [1:0] ph_r;
  logic [7:0] hist_r;
  // Echo each bit; outside its slot the data line toggles, never holds
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_r <= 2'h0;
      tx_bit_en_o <= 1'b0;
      rx_bit_en_o <= 1'b0;
      rx_bit_o <= 1'b0;
      run_o <= 4'h0;
      flags_o <= 8'h00;
      hist_r <= 8'h00;
    end else begin
      ph_r <= ph_r + 2'h1;
      tx_bit_en_o <= ph_r == 2'h0;
      rx_bit_en_o <= ph_r == 2'h2;
      rx_bit_o <= (ph_r == 2'h2) ? tx_bit_i : ~rx_bit_o;
      if (ph_r == 2'h2) begin
        hist_r <= {tx_bit_i, hist_r[7:1]};
        run_o <= !tx_bit_i ? 4'h0 : (run_o == 4'hF) ? run_o : run_o + 4'h1;
        if ({tx_bit_i, hist_r[7:1]} == hdlcdc_pkg::FLAG_OCT) flags_o <= flags_o + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* File: hdlc_datalink_control_tb.sv */
// Purpose: Register and loop-back tests of the data-link controller
// Assumes: Remote end echoes the line
// Notes:   Register polls are bounded
`timescale 1ns/1ps
`default_nettype none
module hdlc_datalink_control_tb;
  logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic        hready, hresp, tx_en, tx_bit, rx_en, rx_bit;
  logic [3:0]  run;
  logic [7:0]  flags, fl0;
  int          n_errors = 0, compares = 0, cyc = 0;
  always #20 clk = ~clk;
  hdlcdc_top i_dut (.CLOCK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .TX_BIT_EN_I(tx_en), .TX_BIT_O(tx_bit), .RX_BIT_EN_I(rx_en),
    .RX_BIT_I(rx_bit));
  hdlcdc_far i_far (.clk_i(clk), .rst_n_i(rst_n), .tx_bit_i(tx_bit), .tx_bit_en_o(tx_en),
    .rx_bit_en_o(rx_en), .rx_bit_o(rx_bit), .run_o(run), .flags_o(flags));
  // One single transfer, held until ready is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic expect_val(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Poll a register until it matches, so frame timing stays free
  task automatic expect_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    for (int i = 0; i < 300; i++) begin
      bus(1'b0, a, 32'h0);
      if ((rd & m) === e) break;
    end
    expect_val(rd & m, e);
  endtask
  task automatic send(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    bus(1'b1, 8'h04, {24'h0, b0});
    bus(1'b1, 8'h04, {24'h0, b1});
    bus(1'b1, 8'h04, {24'h1, b2});
  endtask
  task automatic conclude();
    $display("Checks %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      conclude();
    end
  end
  // Test sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    expect_reg(8'h00, 32'hFFFFFFFF, 32'h0);
    expect_reg(8'h08, 32'hFFFFFFFF, 32'h0);
    bus(1'b1, 8'h40, 32'hFFFFFFFF);
    expect_reg(8'h40, 32'hFFFFFFFF, 32'h0);
    bus(1'b1, 8'h00, 32'h03);
    expect_reg(8'h00, 32'hFFFFFFFF, 32'h03);
    send(8'h7E, 8'hFF, 8'h3C);
    expect_reg(8'h08, 32'h003F00FF, 32'h00050001);
    expect_reg(8'h80, 32'hFF, 32'h7E);
    expect_reg(8'h84, 32'hFF, 32'hFF);
    expect_reg(8'h88, 32'hFF, 32'h3C);
    bus(1'b1, 8'h00, 32'h13);
    send(8'h7E, 8'hFF, 8'h3C);
    send(8'h7E, 8'hFF, 8'h3C);
    expect_reg(8'h08, 32'hFFFF, 32'h0201);
    bus(1'b1, 8'h00, 32'h03);
    send(8'h7E, 8'hFF, 8'h3C);
    expect_reg(8'h08, 32'hFF, 32'h02);
    bus(1'b1, 8'h00, 32'h01);
    send(8'hA5, 8'h3C, 8'h96);
    expect_reg(8'h08, 32'h010000FF, 32'h01000002);
    bus(1'b1, 8'h08, 32'h01000000);
    bus(1'b1, 8'h00, 32'h21);
    send(8'hA5, 8'h3C, 8'h96);
    expect_reg(8'h08, 32'h013F00FF, 32'h00030003);
    bus(1'b1, 8'h00, 32'h25);
    send(8'h11, 8'h22, 8'h33);
    repeat (400) @(posedge clk);
    fl0 = flags;
    repeat (400) @(posedge clk);
    expect_val({31'h0, (flags - fl0) >= 8'h08}, 32'h1);
    expect_reg(8'h08, 32'hFF, 32'h03);
    bus(1'b1, 8'h00, 32'h29);
    for (int i = 0; i < 400 && run < 4'h7; i++) @(posedge clk);
    expect_val({31'h0, run >= 4'h7}, 32'h1);
    repeat (200) @(posedge clk);
    bus(1'b1, 8'h00, 32'h06);
    bus(1'b1, 8'h04, 32'hFF);
    bus(1'b1, 8'h04, 32'h5A);
    expect_reg(8'h0C, 32'h3F, 32'h2D);
    conclude();
  end
endmodule
`default_nettype wire
